// ===== design/hpi_acc_if.sv
// Register access path from the host pin engine to the register file
`timescale 1ns/1ps
`include "hpi_regs.svh"
interface hpi_acc_if;
	logic                req;
	logic                we;
	logic [`HPI_IW-1:0]  addr;
	logic [`HPI_DW-1:0]  wdata;
	logic [`HPI_DW-1:0]  rdata;
	logic                ack;
	modport host (output req, we, addr, wdata, input rdata, ack);
	modport regs (input req, we, addr, wdata, output rdata, ack);
endinterface

// ===== design/hpi_hostif.sv
// Host pin engine: parallel (plain and multiplexed) and serial host cycles
`timescale 1ns/1ps
`include "hpi_regs.svh"
module hpi_hostif
	import hpi_pkg::*;
(
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                rst_b,
	// Synchronised host pins
	input  wire hpi_mode_t           mode,
	input  wire logic                cs_n,
	input  wire logic                rd_n,
	input  wire logic                wr_n,
	input  wire logic                ale,
	input  wire logic [4:0]          addr_pin,
	input  wire logic [`HPI_DW-1:0]  d_in,
	input  wire logic                sclk,
	input  wire logic                sdi,
	// Pin drivers
	output logic [`HPI_DW-1:0]       d_out,
	output logic                     d_oe,
	output logic                     rdy,
	output logic                     sdo,
	output logic                     sdo_oe,
	// Register access
	hpi_acc_if.host                  acc
);
	logic                par, ser, bo, rd_act, wr_rise, sck_rise;
	logic                wr_n_p_q, sclk_p_q, rd_done_q;
	logic [`HPI_IW-1:0]  alat_q, p_addr;
	logic [4:0]          cnt_q;
	logic [`HPI_DW-1:0]  sr_q, sr_d, cmd_q, tx_q;

	assign par      = (mode == HM_NONMUX) || (mode == HM_MUX);
	assign ser      = (mode == HM_SERIAL);
	assign bo       = d_in[`HPI_SERIAL_BIT_ORDER_SEL_BIT];
	assign rd_act   = par && !cs_n && !rd_n;
	assign wr_rise  = par && !cs_n && wr_n && !wr_n_p_q;
	assign sck_rise = ser && !cs_n && sclk && !sclk_p_q;
	assign p_addr   = (mode == HM_MUX) ? alat_q : {1'b0, addr_pin};
	assign sr_d     = bo ? {sr_q[`HPI_DW-2:0], sdi} : {sdi, sr_q[`HPI_DW-1:1]};

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_n_p_q <= 1'b1;
			sclk_p_q <= 1'b0;
		end else begin
			wr_n_p_q <= wr_n;
			sclk_p_q <= sclk;
		end
	end

	// Top two lines carry no address bits
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			alat_q <= '0;
		else if (mode == HM_MUX && ale)
			alat_q <= d_in[`HPI_ADDR_MSB:0];
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			sr_q  <= '0;
			cmd_q <= '0;
		end else if (cs_n || !ser) begin
			cnt_q <= '0;
		end else if (sck_rise) begin
			sr_q  <= sr_d;
			cnt_q <= cnt_q + 5'h01;
			if (cnt_q == `HPI_SER_CMD - 5'h01)
				cmd_q <= sr_d;
		end
	end

	// Ready stays low from parallel cycle launch until the register file answers; serial cycles leave it high
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc.req   <= 1'b0;
			acc.we    <= 1'b0;
			acc.addr  <= '0;
			acc.wdata <= '0;
			rdy       <= 1'b1;
		end else if (acc.ack) begin
			acc.req <= 1'b0;
			rdy     <= 1'b1;
		end else if (!acc.req) begin
			if (rd_act && !rd_done_q) begin
				acc.req  <= 1'b1;
				acc.we   <= 1'b0;
				acc.addr <= p_addr;
				rdy      <= 1'b0;
			end else if (wr_rise) begin
				acc.req   <= 1'b1;
				acc.we    <= 1'b1;
				acc.addr  <= p_addr;
				acc.wdata <= d_in;
				rdy       <= 1'b0;
			end else if (sck_rise && cnt_q == `HPI_SER_CMD - 5'h01 && sr_d[`HPI_SER_RD]) begin
				acc.req  <= 1'b1;
				acc.we   <= 1'b0;
				acc.addr <= sr_d[`HPI_ADDR_MSB:0];
			end else if (sck_rise && cnt_q == `HPI_SER_END - 5'h01 && !cmd_q[`HPI_SER_RD]) begin
				acc.req   <= 1'b1;
				acc.we    <= 1'b1;
				acc.addr  <= cmd_q[`HPI_ADDR_MSB:0];
				acc.wdata <= sr_d;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			d_out     <= '0;
			d_oe      <= 1'b0;
			rd_done_q <= 1'b0;
		end else if (!rd_act) begin
			d_oe      <= 1'b0;
			rd_done_q <= 1'b0;
		end else if (acc.ack && !acc.we) begin
			d_out     <= acc.rdata;
			d_oe      <= 1'b1;
			rd_done_q <= 1'b1;
		end
	end

	// Serial out floats during command phase and writes
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_q   <= '0;
			sdo_oe <= 1'b0;
			sdo    <= 1'b0;
		end else begin
			sdo <= bo ? tx_q[`HPI_DW-1] : tx_q[0];
			if (cs_n || !ser)
				sdo_oe <= 1'b0;
			else if (acc.ack && !acc.we) begin
				tx_q   <= acc.rdata;
				sdo_oe <= 1'b1;
			end else if (sck_rise && sdo_oe)
				tx_q <= bo ? {tx_q[`HPI_DW-2:0], 1'b0} : {1'b0, tx_q[`HPI_DW-1:1]};
		end
	end
endmodule // hpi_hostif

// ===== design/hpi_pkg.sv
// Types shared by the host port block
package hpi_pkg;
	typedef enum logic [1:0] {HM_NONMUX, HM_MUX, HM_SERIAL, HM_HW} hpi_mode_t;
	typedef enum logic [1:0] {LB_NONE, LB_REMOTE, LB_ANALOG} hpi_lb_t;
endpackage

// ===== design/hpi_regs.svh
// Register indices, field positions and reset values of the host port block
`ifndef HPI_REGS_SVH
`define HPI_REGS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define HPI_DW         8
`define HPI_IW         6
`define HPI_APB_DW     32
`define HPI_APB_AW     8

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define HPI_IDX_CTRL   6'h00
`define HPI_IDX_STAT   6'h01
`define HPI_IDX_CLR    6'h02
`define HPI_IDX_EN     6'h03
`define HPI_IDX_PIN    6'h04

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define HPI_CTRL_DRVHI 0
`define HPI_CTRL_SRST  1
`define HPI_EN_RST     8'h00
`define HPI_STAT_RST   8'h00

// ----------------------------------------
// Serial frame and pin positions
// ----------------------------------------
`define HPI_SER_CMD    5'h08
`define HPI_SER_END    5'h10
`define HPI_SER_RD     7
`define HPI_SERIAL_BIT_ORDER_SEL_BIT   7
`define HPI_ADDR_MSB   5

`endif

// ===== design/hpi_top.sv
// Host port block: APB registers, interrupt pin, host pin engine and straps
`timescale 1ns/1ps
`include "hpi_regs.svh"

// Operation
// - Enabled pending event drives interrupt pin low
// - Idle interrupt pin driven high or floated
// - Reset default floats idle interrupt pin
// - Soft reset disables all interrupt sources
// - Plain mode data pins carry read/write data
// - Multiplexed mode ignores top two address lines
// - Bit-order pin picks LSB or MSB first
// - Three-level strap picks channel loopback mode
// - Strap high disables receive termination
// - Ready low until parallel host cycle completes
module hpi_top
	import hpi_pkg::*;
#(
	parameter int N_CH = 8
)(
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`HPI_APB_AW-1:0]  paddr,
	input  wire logic [`HPI_APB_DW-1:0]  pwdata,
	output logic      [`HPI_APB_DW-1:0]  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Interrupt events and pin
	input  wire logic [`HPI_DW-1:0]      irq_src,
	output logic                         irq_out_n,
	output logic                         irq_oe,
	// Host pins
	input  wire logic [1:0]              host_mode,
	input  wire logic                    cs_n,
	input  wire logic                    rd_n,
	input  wire logic                    wr_n,
	input  wire logic                    ale,
	input  wire logic [4:0]              addr_pin,
	input  wire logic [`HPI_DW-1:0]      d_in,
	output logic      [`HPI_DW-1:0]      d_out,
	output logic                         d_oe,
	output logic                         rdy_out,
	input  wire logic                    sclk,
	input  wire logic                    sdi,
	output logic                         sdo,
	output logic                         sdo_oe,
	// Strap pins and line controls
	input  wire logic [N_CH-1:0]         lp_lo,
	input  wire logic [N_CH-1:0]         lp_hi,
	input  wire logic                    rx_term_pin,
	output logic      [2*N_CH-1:0]       chan_loopback_strap,
	output logic                         rx_term_disable
);
	localparam int PW = 22 + 2 * N_CH;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [PW-1:0]        pin_raw, s1_q, s2_q;
	logic [1:0]           mode_s;
	logic                 cs_s, rd_s, wr_s, ale_s, sclk_s, sdi_s, rxt_s;
	logic [4:0]           a_s;
	logic [`HPI_DW-1:0]   d_s;
	logic [N_CH-1:0]      lo_s, hi_s;
	hpi_mode_t            mode;

	assign pin_raw = {host_mode, cs_n, rd_n, wr_n, ale, addr_pin, d_in, sclk, sdi,
		lp_lo, lp_hi, rx_term_pin};

	// Idle-high reset keeps the active-low strobes inactive until real pin levels arrive
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '1;
			s2_q <= '1;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
		end
	end

	assign {mode_s, cs_s, rd_s, wr_s, ale_s, a_s, d_s, sclk_s, sdi_s, lo_s, hi_s, rxt_s} = s2_q;
	assign mode = hpi_mode_t'(mode_s);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic                 drvhi_q;
	logic [`HPI_DW-1:0]   en_q, stat_q;
	logic                 active;
	logic                 apb_set, apb_wr, apb_acc, host_go;
	logic                 w_en;
	logic [`HPI_IW-1:0]   w_idx, apb_idx;
	logic [`HPI_DW-1:0]   w_dat, clr_mask;
	logic                 srst;

	hpi_acc_if acc ();

	function automatic logic reg_ok(input logic [`HPI_IW-1:0] idx);
		return idx <= `HPI_IDX_PIN;
	endfunction

	// Write-only clear register reads as zero
	function automatic logic [`HPI_DW-1:0] rd_val(input logic [`HPI_IW-1:0] idx);
		logic [`HPI_DW-1:0] v;
		v = '0;
		case (idx)
			`HPI_IDX_CTRL: v[`HPI_CTRL_DRVHI] = drvhi_q;
			`HPI_IDX_STAT: v = stat_q;
			`HPI_IDX_EN:   v = en_q;
			`HPI_IDX_PIN:  v = {{(`HPI_DW-3){1'b0}}, rx_term_disable, mode_s};
			default:       v = '0;
		endcase
		return v;
	endfunction

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign apb_idx = paddr[`HPI_APB_AW-1:2];
	assign apb_set = psel && !penable;
	assign apb_acc = psel && penable && pready;
	assign apb_wr  = apb_acc && pwrite && !pslverr;

	// Zero wait states: answer in the first access cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_set;
			if (apb_set) begin
				prdata  <= {{(`HPI_APB_DW-`HPI_DW){1'b0}}, rd_val(apb_idx)};
				pslverr <= !reg_ok(apb_idx);
			end
		end
	end

	// ----------------------------------------
	// Write arbitration
	// ----------------------------------------
	// APB wins a shared cycle; the host request simply waits one more cycle
	assign host_go = acc.req && !acc.ack && !apb_acc;
	assign w_en    = apb_wr || (host_go && acc.we);
	assign w_idx   = apb_wr ? apb_idx : acc.addr;
	assign w_dat   = apb_wr ? pwdata[`HPI_DW-1:0] : acc.wdata;
	assign srst    = w_en && w_idx == `HPI_IDX_CTRL && w_dat[`HPI_CTRL_SRST];
	assign clr_mask = (w_en && w_idx == `HPI_IDX_CLR) ? w_dat : '0;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc.ack   <= 1'b0;
			acc.rdata <= '0;
		end else begin
			acc.ack <= host_go;
			if (host_go)
				acc.rdata <= rd_val(acc.addr);
		end
	end

	// ----------------------------------------
	// Control, enable and status
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			drvhi_q <= 1'b0;
		else if (srst)
			drvhi_q <= 1'b0;
		else if (w_en && w_idx == `HPI_IDX_CTRL)
			drvhi_q <= w_dat[`HPI_CTRL_DRVHI];
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			en_q <= `HPI_EN_RST;
		else if (srst)
			en_q <= `HPI_EN_RST;
		else if (w_en && w_idx == `HPI_IDX_EN)
			en_q <= w_dat;
	end

	// A new event beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			stat_q <= `HPI_STAT_RST;
		else
			stat_q <= (stat_q & ~clr_mask) | irq_src;
	end

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	assign active = |(stat_q & en_q);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_out_n <= 1'b1;
			irq_oe    <= 1'b0;
		end else begin
			irq_out_n <= !active;
			irq_oe    <= active || drvhi_q;
		end
	end

	// ----------------------------------------
	// Host pin engine
	// ----------------------------------------
	// Seven low data pins are assumed grounded by the board in serial mode
	hpi_hostif u_host (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.mode     (mode),
		.cs_n     (cs_s),
		.rd_n     (rd_s),
		.wr_n     (wr_s),
		.ale      (ale_s),
		.addr_pin (a_s),
		.d_in     (d_s),
		.sclk     (sclk_s),
		.sdi      (sdi_s),
		.d_out    (d_out),
		.d_oe     (d_oe),
		.rdy      (rdy_out),
		.sdo      (sdo),
		.sdo_oe   (sdo_oe),
		.acc      (acc.host)
	);

	// ----------------------------------------
	// Hardware-mode straps
	// ----------------------------------------
	// The analog front end reduces each three-level pin to two comparators
	for (genvar ch = 0; ch < N_CH; ch++) begin : g_lb
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b)
				chan_loopback_strap[2*ch +: 2] <= LB_NONE;
			else if (mode != HM_HW)
				chan_loopback_strap[2*ch +: 2] <= LB_NONE;
			else if (lo_s[ch])
				chan_loopback_strap[2*ch +: 2] <= LB_REMOTE;
			else if (hi_s[ch])
				chan_loopback_strap[2*ch +: 2] <= LB_ANALOG;
			else
				chan_loopback_strap[2*ch +: 2] <= LB_NONE;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rx_term_disable <= 1'b0;
		else
			rx_term_disable <= (mode == HM_HW) && rxt_s;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_srst_wr;
		srst;
	endsequence

	sequence s_host_wait;
		acc.req && !acc.ack;
	endsequence

	a_irq_assert: assert property (active |=> !irq_out_n && irq_oe)
		else $error("interrupt not driven low for enabled event");

	a_irq_drvhi: assert property (!active && drvhi_q |=> irq_out_n && irq_oe)
		else $error("idle interrupt pin not driven high");

	a_irq_float: assert property (!active && !drvhi_q |=> !irq_oe)
		else $error("idle interrupt pin driven while float selected");

	a_srst_clear: assert property (s_srst_wr |=> en_q == `HPI_EN_RST ##1 !irq_oe)
		else $error("soft reset left sources enabled or pin driven");

	a_rdata_mode: assert property ($rose(d_oe) |-> $past(mode == HM_NONMUX || mode == HM_MUX, 2))
		else $error("data bus driven outside parallel mode");

	a_ready_wait: assert property (s_host_wait |-> !rdy_out || mode == HM_SERIAL)
		else $error("ready high while host cycle pending");

	a_ready_done: assert property (acc.ack && mode != HM_SERIAL |=> rdy_out)
		else $error("ready not raised at cycle end");

	a_lb_remote: assert property (mode == HM_HW && lo_s[0] |=>
		chan_loopback_strap[1:0] == LB_REMOTE)
		else $error("low strap did not select remote loopback");

	a_rxterm_off: assert property (mode == HM_HW && rxt_s |=> rx_term_disable)
		else $error("termination not disabled by strap");

	a_irq_release: assert property ($fell(active) |=> irq_out_n)
		else $error("interrupt not released");
endmodule // hpi_top

// ===== verification/hpi_host_model.sv
// Host processor model driving the parallel and serial host pins
`timescale 1ns/1ps
module hpi_host_model (
	// Clock
	input  wire logic       mclk,
	// Device outputs
	input  wire logic       rdy_out,
	input  wire logic       sdo,
	input  wire logic       sdo_oe,
	input  wire logic [7:0] d_pin,
	// Host drivers
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            ale,
	output logic [4:0]      addr_pin,
	output logic [7:0]      d_drv,
	output logic            sclk,
	output logic            sdi
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		ale = 1'b0;
		addr_pin = 5'h00;
		d_drv = 8'h00;
		sclk = 1'b0;
		sdi = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Top two bits carry junk so a decoder that uses them misses the register
	task automatic addr_phase(input logic mux, input logic [5:0] idx);
		cs_n <= 1'b0;
		addr_pin <= mux ? 5'h00 : idx[4:0];
		if (mux) begin
			ale <= 1'b1;
			d_drv <= {2'b11, idx};
			cyc(4);
			ale <= 1'b0;
			cyc(3);
		end
	endtask

	task automatic wait_done(output logic waited);
		waited = 1'b0;
		repeat (8) begin
			@(posedge mclk);
			if (rdy_out === 1'b0) waited = 1'b1;
		end
		while (rdy_out !== 1'b1) @(posedge mclk);
	endtask

	task automatic par_write(input logic mux, input logic [5:0] idx, input logic [7:0] wd);
		logic w;
		cyc(1);
		addr_phase(mux, idx);
		d_drv <= wd;
		wr_n <= 1'b0;
		cyc(6);
		wr_n <= 1'b1;
		wait_done(w);
		cs_n <= 1'b1;
		d_drv <= ~wd;
		cyc(3);
	endtask

	// Released data lines show the inverse of the last value, never a held copy
	task automatic par_read(input logic mux, input logic [5:0] idx, output logic [7:0] rdat,
			output logic waited);
		cyc(1);
		addr_phase(mux, idx);
		if (mux)
			d_drv <= ~d_drv;
		rd_n <= 1'b0;
		wait_done(waited);
		rdat = d_pin;
		rd_n <= 1'b1;
		cs_n <= 1'b1;
		cyc(3);
	endtask

	task automatic ser(input logic rd, input logic msb, input logic [5:0] idx,
			input logic [7:0] wd, output logic [7:0] rdat);
		logic [7:0] b;
		int j;
		cyc(1);
		d_drv <= {msb, 7'h00};
		cyc(3);
		cs_n <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			b = (k < 8) ? {rd, 1'b0, idx} : wd;
			j = msb ? 7 - (k % 8) : k % 8;
			sdi <= b[j];
			cyc(4);
			if (k >= 8) rdat[j] = sdo_oe ? sdo : 1'bx;
			sclk <= 1'b1;
			cyc(4);
			sclk <= 1'b0;
		end
		cyc(4);
		cs_n <= 1'b1;
		sdi <= ~sdi;
		cyc(3);
	endtask
endmodule // hpi_host_model

// ===== verification/hpi_top_tb.sv
// Self-checking bench of the host port block
`timescale 1ns/1ps
`include "hpi_regs.svh"
module hpi_top_tb
	import hpi_pkg::*;
;
	logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, irq_src, d_in, d_out, d_drv, lp_lo, lp_hi, hd;
	logic [31:0] pwdata, prdata, rd;
	logic        irq_out_n, irq_oe, cs_n, rd_n, wr_n, ale, d_oe, rdy_out;
	logic        sclk, sdi, sdo, sdo_oe, rx_term_pin, rx_term_disable, err, w;
	logic [1:0]  host_mode;
	logic [4:0]  addr_pin;
	logic [15:0] chan_loopback_strap;
	int          error_cnt, samples_checked, cycles;

	assign d_in = d_oe ? d_out : d_drv;

	hpi_top #(.N_CH(8)) u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_src(irq_src), .irq_out_n(irq_out_n), .irq_oe(irq_oe),
		.host_mode(host_mode), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
		.addr_pin(addr_pin), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .rdy_out(rdy_out),
		.sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .lp_lo(lp_lo), .lp_hi(lp_hi),
		.rx_term_pin(rx_term_pin), .chan_loopback_strap(chan_loopback_strap),
		.rx_term_disable(rx_term_disable));

	hpi_host_model u_host (.mclk(mclk), .rdy_out(rdy_out), .sdo(sdo), .sdo_oe(sdo_oe),
		.d_pin(d_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .addr_pin(addr_pin),
		.d_drv(d_drv), .sclk(sclk), .sdi(sdi));

	always #50 mclk = ~mclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [7:0] s);
		@(posedge mclk);
		irq_src <= s;
		@(posedge mclk);
		irq_src <= 8'h00;
		repeat (3) @(posedge mclk);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("irq_oe", 1'b0, irq_oe);
		chk("rdy_out", 1'b1, rdy_out);
		apb(1'b0, `HPI_IDX_EN, 8'h00);
		chk("enable", 32'h0, rd);
		apb(1'b0, `HPI_IDX_CTRL, 8'h00);
		chk("ctrl", 32'h0, rd);
	endtask

	task automatic t_irq();
		apb(1'b1, `HPI_IDX_EN, 8'h05);
		pulse(8'h04);
		chk("irq_out_n", 1'b0, irq_out_n);
		chk("irq_oe", 1'b1, irq_oe);
		pulse(8'h02);
		apb(1'b0, `HPI_IDX_STAT, 8'h00);
		chk("status", 32'h06, rd);
		apb(1'b1, `HPI_IDX_CLR, 8'h04);
		repeat (2) @(posedge mclk);
		chk("irq_oe", 1'b0, irq_oe);
		apb(1'b1, `HPI_IDX_CTRL, 8'h01);
		repeat (2) @(posedge mclk);
		chk("irq_oe", 1'b1, irq_oe);
		chk("irq_out_n", 1'b1, irq_out_n);
		pulse(8'h01);
		chk("irq_out_n", 1'b0, irq_out_n);
		apb(1'b1, `HPI_IDX_CLR, 8'h01);
		repeat (2) @(posedge mclk);
		chk("irq_out_n", 1'b1, irq_out_n);
		apb(1'b1, `HPI_IDX_CTRL, 8'h02);
		apb(1'b0, `HPI_IDX_EN, 8'h00);
		chk("enable", 32'h0, rd);
		pulse(8'h01);
		chk("irq_oe", 1'b0, irq_oe);
		apb(1'b1, `HPI_IDX_EN, 8'h01);
		repeat (2) @(posedge mclk);
		chk("irq_out_n", 1'b0, irq_out_n);
		apb(1'b0, 6'h05, 8'h00);
		chk("pslverr", 1'b1, err);
		chk("unmapped", 32'h0, rd);
	endtask

	task automatic t_par(input logic mux, input logic [7:0] v);
		host_mode <= {1'b0, mux};
		repeat (4) @(posedge mclk);
		u_host.par_write(mux, `HPI_IDX_EN, v);
		apb(1'b0, `HPI_IDX_EN, 8'h00);
		chk("host write", v, rd);
		u_host.par_read(mux, `HPI_IDX_EN, hd, w);
		chk("host read", v, hd);
		chk("wait state", 1'b1, w);
	endtask

	task automatic t_ser(input logic msb, input logic [7:0] v);
		host_mode <= 2'd2;
		repeat (4) @(posedge mclk);
		u_host.ser(1'b0, msb, `HPI_IDX_EN, v, hd);
		apb(1'b0, `HPI_IDX_EN, 8'h00);
		chk("serial write", v, rd);
		u_host.ser(1'b1, msb, `HPI_IDX_EN, 8'h00, hd);
		chk("serial read", v, hd);
	endtask

	task automatic t_hw();
		logic [15:0] exp;
		host_mode <= 2'd3;
		for (int i = 0; i < 8; i++) begin
			lp_lo[i] <= (i % 3 == 1);
			lp_hi[i] <= (i % 3 == 2);
			exp[2*i +: 2] = (i % 3 == 1) ? LB_REMOTE : (i % 3 == 2) ? LB_ANALOG : LB_NONE;
		end
		rx_term_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("loopback", exp, chan_loopback_strap);
		chk("rx_term_disable", 1'b1, rx_term_disable);
		apb(1'b0, `HPI_IDX_PIN, 8'h00);
		chk("pin status", 32'h07, rd);
		rx_term_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("rx_term_disable", 1'b0, rx_term_disable);
	endtask

	// Mid-run reset must bring back the floating idle pin and cleared setup
	task automatic t_rst_again();
		apb(1'b1, `HPI_IDX_CTRL, 8'h01);
		repeat (2) @(posedge mclk);
		chk("irq_oe", 1'b1, irq_oe);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("irq_oe", 1'b0, irq_oe);
		chk("irq_out_n", 1'b1, irq_out_n);
		apb(1'b0, `HPI_IDX_CTRL, 8'h00);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, `HPI_IDX_EN, 8'h00);
		chk("enable", 32'h0, rd);
	endtask

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		irq_src = 8'h00;
		host_mode = 2'd0;
		lp_lo = 8'h00;
		lp_hi = 8'h00;
		rx_term_pin = 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_irq();
		t_par(1'b0, 8'hA5);
		t_par(1'b1, 8'h5A);
		t_ser(1'b0, 8'h96);
		t_ser(1'b1, 8'h1D);
		t_hw();
		t_rst_again();
		results();
	end

	// Whole run needs under a thousand cycles; this ceiling only catches a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			results();
		end
	end
endmodule // hpi_top_tb
